// ### hdl/mico_pkg.sv
// Purpose: Constants and types for the motion interrupt configuration and output stage
// Assumes: 10 MHz clock, 8-bit register port
// Notes:   Byte addresses equal the printed register offsets
package mico_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_SRC_SELECT   = 8'h1e;
	localparam logic [7:0] OFS_PIN_CONFIG   = 8'h20;
	localparam logic [7:0] OFS_LATCH_MODE   = 8'h21;
	localparam logic [7:0] OFS_LOWG_DELAY   = 8'h22;
	localparam logic [7:0] OFS_LOWG_THRESH  = 8'h23;
	localparam logic [7:0] OFS_HYST_MODE    = 8'h24;
	localparam logic [7:0] OFS_IRQ_STATUS   = 8'h30;
	localparam logic [7:0] OFS_IRQ_MASK     = 8'h31;
	localparam logic [7:0] OFS_MAP_A        = 8'h32;
	localparam logic [7:0] OFS_MAP_B        = 8'h33;

	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] RST_SRC_SELECT   = 8'h00;
	localparam logic [7:0] RST_PIN_CONFIG   = 8'h05;
	localparam logic [7:0] RST_LATCH_MODE   = 8'h00;
	localparam logic [7:0] RST_LOWG_DELAY   = 8'h09;
	localparam logic [7:0] RST_LOWG_THRESH  = 8'h30;
	localparam logic [7:0] RST_HYST_MODE    = 8'h81;
	localparam logic [7:0] RST_ZERO         = 8'h00;
	localparam logic [7:0] MASK_SRC_SELECT  = 8'h3f;
	localparam logic [7:0] MASK_PIN_CONFIG  = 8'h0f;
	localparam logic [7:0] MASK_LATCH_MODE  = 8'h0f;
	localparam logic [7:0] MASK_HYST_MODE   = 8'hc7;
	localparam int         BIT_CLEAR_LATCH  = 7;
	localparam int         BIT_SRC_DATA     = 5;
	localparam int         BIT_A_POLARITY   = 0;
	localparam int         BIT_A_OPEN_DRAIN = 1;
	localparam int         BIT_B_POLARITY   = 2;
	localparam int         BIT_B_OPEN_DRAIN = 3;
	localparam int         BIT_LOWG_MODE    = 2;
	localparam int         NUM_ENGINES      = 6;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint CLK_HZ          = 10_000_000;
	localparam longint US_PER_S        = 1_000_000;
	localparam longint LOWG_STEP_US    = 2000;
	localparam longint LOWG_STEP_CYC   = (LOWG_STEP_US * CLK_HZ) / US_PER_S;
	localparam longint HOLD_US [16] = '{0, 250_000, 500_000, 1_000_000, 2_000_000,
		4_000_000, 8_000_000, 0, 0, 250, 500, 1000, 12_500, 25_000, 50_000, 0};

	typedef struct packed {
		logic [5:0] src_unfiltered;
		logic       lowg_sum_mode;
		logic [1:0] lowg_hysteresis_field;
		logic [1:0] highg_hysteresis_field;
		logic [7:0] lowg_threshold_field;
		logic [7:0] lowg_delay;
	} mico_engine_cfg_t;

	typedef struct packed {
		logic       req;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mico_bus_req_t;

endpackage

// ### hdl/mico_top.sv
// Purpose: Interrupt pin stage with latch modes and engine configuration registers
// Assumes: Bus strobes are one cycle and never together
// Notes:   Engines outside report a raw level per condition
`timescale 1ns/1ns

// Summary of operation
// [R1] Each engine gets a select bit choosing filtered (0) or unfiltered (1) data.
// [R2] Bit 5 of the source register selects unfiltered data for the new-data engine.
// [R3] Pin b is push-pull when its drive bit is 0 and open-drain when it is 1.
// [R4] Pin a is push-pull when its drive bit is 0 and open-drain when it is 1.
// [R5] Pin b is active low when its polarity bit is 0, active high when 1, reset 1.
// [R6] Pin a is active low when its polarity bit is 0, active high when 1, reset 1.
// [R7] Writing 1 to latch bit 7 clears all latched interrupts except one whose condition rises in that cycle, and 0 does nothing.
// [R8] Latch codes 0 and 8 are non-latched, codes 7 and 15 fully latched.
// [R9] Codes 1 to 6 hold an interrupt 250 ms, 500 ms, 1 s, 2 s, 4 s, 8 s.
// [R10] Codes 9 to 14 hold an interrupt 250 us, 500 us, 1 ms, 12.5 ms, 25 ms, 50 ms.
// [R11] The low-g persistence is (delay + 1) x 2 ms, reset 9.
// [R12] The low-g threshold is the 8-bit field times 7.81 mg, reset 375 mg.
// [R13] High-g hysteresis is the 2-bit field scaled by the range.
// [R14] Low-g mode 0 is per axis, 1 is summed axes.
// [R15] Low-g hysteresis is the 2-bit field times 125 mg on any range.
// [R16] A condition reaches a pin only when its mapping bit for that pin is set.
// [R17] Software writes zero to reserved bits and treats the clear bit as one-shot.
module mico_top #(
	parameter int NUM_COND = 8
) (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic [7:0]                reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	input  wire logic [NUM_COND-1:0]       cond_raw,
	output mico_pkg::mico_engine_cfg_t     engine_cfg,
	output logic                           lowg_step_tick,
	output logic                           irq,
	output logic                           irq_pin_a_o,
	output logic                           irq_pin_a_oe,
	output logic                           irq_pin_b_o,
	output logic                           irq_pin_b_oe
);

	initial begin
		if (NUM_COND < 1 || NUM_COND > 8) begin
			$error("NUM_COND must be 1 to 8");
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] src_select;
	logic [7:0] pin_config;
	logic [7:0] latch_mode;
	logic [7:0] lowg_delay;
	logic [7:0] lowg_threshold;
	logic [7:0] hyst_mode;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [7:0] map_a;
	logic [7:0] map_b;
	logic       clear_latched;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_select     <= mico_pkg::RST_SRC_SELECT;
			pin_config     <= mico_pkg::RST_PIN_CONFIG; // [R5] [R6]
			latch_mode     <= mico_pkg::RST_LATCH_MODE;
			lowg_delay     <= mico_pkg::RST_LOWG_DELAY; // [R11]
			lowg_threshold <= mico_pkg::RST_LOWG_THRESH; // [R12]
			hyst_mode      <= mico_pkg::RST_HYST_MODE;
			irq_mask       <= mico_pkg::RST_ZERO;
			map_a          <= mico_pkg::RST_ZERO;
			map_b          <= mico_pkg::RST_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
				mico_pkg::OFS_SRC_SELECT:  src_select     <= reg_wdata & mico_pkg::MASK_SRC_SELECT;
				mico_pkg::OFS_PIN_CONFIG:  pin_config     <= reg_wdata & mico_pkg::MASK_PIN_CONFIG;
				mico_pkg::OFS_LATCH_MODE:  latch_mode     <= reg_wdata & mico_pkg::MASK_LATCH_MODE;
				mico_pkg::OFS_LOWG_DELAY:  lowg_delay     <= reg_wdata;
				mico_pkg::OFS_LOWG_THRESH: lowg_threshold <= reg_wdata;
				mico_pkg::OFS_HYST_MODE:   hyst_mode      <= reg_wdata & mico_pkg::MASK_HYST_MODE;
				mico_pkg::OFS_IRQ_MASK:    irq_mask       <= reg_wdata;
				mico_pkg::OFS_MAP_A:       map_a          <= reg_wdata;
				mico_pkg::OFS_MAP_B:       map_b          <= reg_wdata;
				default: ;
			endcase
		end
	end

	// One-shot clear command, never stored
	assign clear_latched = reg_wr && reg_addr == mico_pkg::OFS_LATCH_MODE
		&& reg_wdata[mico_pkg::BIT_CLEAR_LATCH]; // [R7]

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= mico_pkg::RST_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				mico_pkg::OFS_SRC_SELECT:  reg_rdata <= src_select;
				mico_pkg::OFS_PIN_CONFIG:  reg_rdata <= pin_config;
				mico_pkg::OFS_LATCH_MODE:  reg_rdata <= latch_mode;
				mico_pkg::OFS_LOWG_DELAY:  reg_rdata <= lowg_delay;
				mico_pkg::OFS_LOWG_THRESH: reg_rdata <= lowg_threshold;
				mico_pkg::OFS_HYST_MODE:   reg_rdata <= hyst_mode;
				mico_pkg::OFS_IRQ_STATUS:  reg_rdata <= irq_status;
				mico_pkg::OFS_IRQ_MASK:    reg_rdata <= irq_mask;
				mico_pkg::OFS_MAP_A:       reg_rdata <= map_a;
				mico_pkg::OFS_MAP_B:       reg_rdata <= map_b;
				default:                   reg_rdata <= mico_pkg::RST_ZERO;
			endcase
		end else begin
			reg_rdata <= mico_pkg::RST_ZERO;
		end
	end

	// ----------------------------------------
	// Engine configuration
	// ----------------------------------------
	always_comb begin
		engine_cfg.src_unfiltered         = src_select[mico_pkg::NUM_ENGINES-1:0]; // [R1] [R2]
		engine_cfg.lowg_sum_mode          = hyst_mode[mico_pkg::BIT_LOWG_MODE]; // [R14]
		engine_cfg.lowg_hysteresis_field  = hyst_mode[1:0]; // [R15]
		engine_cfg.highg_hysteresis_field = hyst_mode[7:6]; // [R13]
		engine_cfg.lowg_threshold_field   = lowg_threshold; // [R12]
		engine_cfg.lowg_delay             = lowg_delay; // [R11]
	end

	// 2 ms tick for the low-g persistence counter
	localparam int STEP_CYC = int'(mico_pkg::LOWG_STEP_CYC);
	logic [31:0] step_cnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_cnt       <= '0;
			lowg_step_tick <= 1'b0;
		end else if (step_cnt == 32'(STEP_CYC - 1)) begin
			step_cnt       <= '0;
			lowg_step_tick <= 1'b1; // [R11]
		end else begin
			step_cnt       <= step_cnt + 32'h1;
			lowg_step_tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// Latch behaviour per condition
	// ----------------------------------------
	typedef enum logic [1:0] {
		MICO_NONLATCHED,
		MICO_TEMPORARY,
		MICO_LATCHED
	} mico_latch_t;

	mico_latch_t latch_kind;
	logic [31:0] hold_cyc;
	logic [3:0]  code;
	assign code = latch_mode[3:0];

	always_comb begin
		case (code)
			4'h0, 4'h8: latch_kind = MICO_NONLATCHED; // [R8]
			4'h7, 4'hf: latch_kind = MICO_LATCHED; // [R8]
			default:    latch_kind = MICO_TEMPORARY; // [R9] [R10]
		endcase
		hold_cyc = 32'((mico_pkg::HOLD_US[code] * mico_pkg::CLK_HZ) / mico_pkg::US_PER_S);
	end

	logic [NUM_COND-1:0] held;
	logic [NUM_COND-1:0] cond_prev;
	logic [31:0]         hold_cnt [NUM_COND];

	for (genvar i = 0; i < NUM_COND; i++) begin : g_latch
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				held[i]      <= 1'b0;
				cond_prev[i] <= 1'b0;
				hold_cnt[i]  <= '0;
			end else begin
				cond_prev[i] <= cond_raw[i];
				if (cond_raw[i] && !cond_prev[i]) begin
					held[i]     <= latch_kind != MICO_NONLATCHED;
					hold_cnt[i] <= hold_cyc;
				end else if (clear_latched) begin
					held[i]     <= 1'b0; // [R7]
					hold_cnt[i] <= '0;
				end else if (latch_kind == MICO_NONLATCHED) begin
					held[i] <= 1'b0; // [R8]
				end else if (latch_kind == MICO_TEMPORARY && held[i]) begin
					if (hold_cnt[i] <= 32'h1) begin
						held[i] <= 1'b0; // [R9] [R10]
					end
					hold_cnt[i] <= hold_cnt[i] - 32'h1;
				end
			end
		end
	end

	logic [NUM_COND-1:0] active;
	assign active = held | cond_raw;

	// ----------------------------------------
	// Status, mask and software interrupt
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= mico_pkg::RST_ZERO;
		end else begin
			// Set wins over write-one-to-clear
			irq_status <= (irq_status & ~((reg_wr && reg_addr == mico_pkg::OFS_IRQ_STATUS)
				? reg_wdata : 8'h00)) | 8'(active);
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	logic pin_a_assert;
	logic pin_b_assert;
	logic pin_a_level;
	logic pin_b_level;
	assign pin_a_assert = |(8'(active) & map_a); // [R16]
	assign pin_b_assert = |(8'(active) & map_b); // [R16]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_a_level <= 1'b0;
			pin_b_level <= 1'b0;
		end else begin
			pin_a_level <= pin_a_assert ~^ pin_config[mico_pkg::BIT_A_POLARITY]; // [R6]
			pin_b_level <= pin_b_assert ~^ pin_config[mico_pkg::BIT_B_POLARITY]; // [R5]
		end
	end

	// Open drain drives only the low level
	assign irq_pin_a_o  = pin_a_level;
	assign irq_pin_a_oe = !pin_config[mico_pkg::BIT_A_OPEN_DRAIN] || !pin_a_level; // [R4]
	assign irq_pin_b_o  = pin_b_level;
	assign irq_pin_b_oe = !pin_config[mico_pkg::BIT_B_OPEN_DRAIN] || !pin_b_level; // [R3]

endmodule // mico_top

// ### verification/mico_chk.sv
// Purpose: Port checker for the interrupt pin stage
// Assumes: Shadows follow register writes
// Notes:   Pin levels checked in non-latched modes
`timescale 1ns/1ns
module mico_chk #(
	parameter int NUM_COND = 8
) (
	input wire logic                       clk,
	input wire logic                       rst_n,
	input wire logic [7:0]                 reg_addr,
	input wire logic [7:0]                 reg_wdata,
	input wire logic                       reg_wr,
	input wire logic [NUM_COND-1:0]        cond_raw,
	input wire mico_pkg::mico_engine_cfg_t engine_cfg,
	input wire logic                       irq_pin_a_o,
	input wire logic                       irq_pin_a_oe,
	input wire logic                       irq_pin_b_o,
	input wire logic                       irq_pin_b_oe
);
	logic [7:0]          pc;
	logic [2:0]          lm;
	logic [NUM_COND-1:0] ma;
	logic [NUM_COND-1:0] mb;
	logic                quiet;
	logic                ea;
	logic                eb;
	wire logic           w = reg_wr;
	wire logic           nl = lm == 3'h0;
	wire logic           al = irq_pin_a_oe ? irq_pin_a_o : 1'b1;
	wire logic           bl = irq_pin_b_oe ? irq_pin_b_o : 1'b1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// Shadow copies of pin settings
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= 8'h05;
			lm <= 3'h0;
			ma <= '0;
			mb <= '0;
			quiet <= 1'b1;
			ea <= 1'b0;
			eb <= 1'b0;
		end else begin
			if (w && reg_addr == 8'h20) pc <= reg_wdata;
			if (w && reg_addr == 8'h21) lm <= reg_wdata[2:0];
			if (w && reg_addr == 8'h32) ma <= reg_wdata[NUM_COND-1:0];
			if (w && reg_addr == 8'h33) mb <= reg_wdata[NUM_COND-1:0];
			quiet <= !w;
			ea <= (|(cond_raw & ma)) ~^ pc[0];
			eb <= (|(cond_raw & mb)) ~^ pc[2];
		end
	end
	AST_SRC: assert property (w && reg_addr == 8'h1e |=>
		{2'h0, engine_cfg.src_unfiltered} == ($past(reg_wdata) & 8'h3f)) else $error("src");
	AST_DLY: assert property (w && reg_addr == 8'h22 |=>
		engine_cfg.lowg_delay == $past(reg_wdata)) else $error("delay");
	AST_THR: assert property (w && reg_addr == 8'h23 |=>
		engine_cfg.lowg_threshold_field == $past(reg_wdata)) else $error("threshold");
	AST_HYS: assert property (w && reg_addr == 8'h24 |=> {engine_cfg.highg_hysteresis_field,
		3'h0, engine_cfg.lowg_sum_mode, engine_cfg.lowg_hysteresis_field} ==
		($past(reg_wdata) & 8'hc7)) else $error("hysteresis");
	AST_A_DRV: assert property (quiet |->
		(pc[1] ? !(irq_pin_a_oe && irq_pin_a_o) : irq_pin_a_oe)) else $error("pin a drive");
	AST_B_DRV: assert property (quiet |->
		(pc[3] ? !(irq_pin_b_oe && irq_pin_b_o) : irq_pin_b_oe)) else $error("pin b drive");
	AST_A_LVL: assert property (nl |=> al == ea) else $error("pin a level");
	AST_B_LVL: assert property (nl |=> bl == eb) else $error("pin b level");
	cover property (w && reg_addr == 8'h21 && reg_wdata[7]);
	cover property (quiet && pc[1] && !irq_pin_a_oe);
	cover property (!nl && al == pc[0]);
endmodule // mico_chk

bind mico_top mico_chk #(.NUM_COND(NUM_COND)) i_mico_chk (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .cond_raw(cond_raw),
	.engine_cfg(engine_cfg), .irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe(irq_pin_a_oe),
	.irq_pin_b_o(irq_pin_b_o), .irq_pin_b_oe(irq_pin_b_oe));

// ### verification/mico_host_model.sv
// Purpose: Host side of the two interrupt pins
// Assumes: Board pull-ups on both pins
// Notes:   Released pins read high
`timescale 1ns/1ns
module mico_host_model (
	input  wire logic a_o,
	input  wire logic a_oe,
	input  wire logic b_o,
	input  wire logic b_oe,
	output logic      pin_a,
	output logic      pin_b
);
	assign pin_a = a_oe ? a_o : 1'b1;
	assign pin_b = b_oe ? b_o : 1'b1;
endmodule // mico_host_model

// ### verification/test_motion_irq_config_output.sv
// Purpose: Self-checking bench for the interrupt pin stage
// Assumes: Host model resolves the pins
// Notes:   Only the shortest hold code is timed
`timescale 1ns/1ns
module test_motion_irq_config_output;
	logic       clk, rst_n, reg_wr, reg_rd, rd_d, irq, tick, pa, pb, ao, aoe, bo, boe, la, lb;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cond_raw, e;
	logic [7:0] expq[$];
	int         failures, num_checks, n;
	logic [7:0] ofs[11] = '{8'h1e, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30, 8'h31, 8'h32,
		8'h33, 8'h40};
	logic [7:0] rv[11] = '{8'h00, 8'h05, 8'h00, 8'h09, 8'h30, 8'h81, 0, 0, 0, 0, 0};
	logic [7:0] rm[11] = '{8'h3f, 8'h0f, 8'h0f, 8'hff, 8'hff, 8'hc7, 0, 8'hff, 8'hff, 8'hff, 0};
	logic [7:0] lc[4] = '{8'h00, 8'h08, 8'h07, 8'h0f};
	wire logic [7:0] pins = {4'h0, pa, pb, aoe, boe};
	mico_top i_mico_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cond_raw(cond_raw),
		.engine_cfg(), .lowg_step_tick(tick), .irq(irq), .irq_pin_a_o(ao),
		.irq_pin_a_oe(aoe), .irq_pin_b_o(bo), .irq_pin_b_oe(boe));
	mico_host_model i_mico_host_model (.a_o(ao), .a_oe(aoe), .b_o(bo), .b_oe(boe),
		.pin_a(pa), .pin_b(pb));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] x);
		num_checks++;
		if (got !== x) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, x);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		expq.push_back(x);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic pulse(input logic [7:0] v);
		cond_raw <= v;
		@(posedge clk);
		cond_raw <= 8'h00;
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic end_sim;
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		if (rd_d)
			chk(reg_rdata, expq.pop_front());
		rd_d <= reg_rd;
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{rst_n, reg_wr, reg_rd, rd_d, reg_addr, reg_wdata, cond_raw} = '0;
		n = $urandom(38592);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ofs[i])
			rd(ofs[i], rv[i]);
		foreach (ofs[i]) begin
			e = 8'($urandom);
			wr(ofs[i], e);
			rd(ofs[i], e & rm[i]);
		end
		wr(8'h21, 8'h80);
		wr(8'h32, 8'h01);
		wr(8'h33, 8'h02);
		for (int i = 0; i < 16; i++) begin
			wr(8'h20, 8'(i));
			for (int k = 0; k < 2; k++) begin
				cond_raw <= {6'h0, k[0], k[0]};
				settle();
				la = k[0] ~^ i[0];
				lb = k[0] ~^ i[2];
				chk(pins, {4'h0, la, lb, !i[1] || !la, !i[3] || !lb});
			end
		end
		cond_raw <= 8'h00;
		foreach (lc[j]) begin
			wr(8'h21, lc[j]);
			pulse(8'h01);
			settle();
			la = lc[j][2:0] == 3'h7;
			e = {4'h0, la, 1'b0, !la, 1'b1};
			chk(pins, e);
			wr(8'h21, lc[j]);
			settle();
			chk(pins, e);
			wr(8'h21, 8'h80 | lc[j]);
			settle();
			chk(pins, 8'h03);
		end
		wr(8'h21, 8'h09);
		pulse(8'h01);
		repeat (2390) @(posedge clk);
		settle();
		chk(pins, 8'h09);
		repeat (200) @(posedge clk);
		settle();
		chk(pins, 8'h03);
		wr(8'h21, 8'h80);
		wr(8'h30, 8'hff);
		wr(8'h31, 8'h01);
		pulse(8'h02);
		settle();
		chk({7'h0, irq}, 8'h00);
		wr(8'h31, 8'h03);
		settle();
		chk({7'h0, irq}, 8'h01);
		rd(8'h30, 8'h02);
		wr(8'h30, 8'h02);
		settle();
		chk({7'h0, irq}, 8'h00);
		n = 0;
		while (tick !== 1'b1 && n < 20001) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 20001);
		chk({7'h0, n == 20000}, 8'h01);
		end_sim();
	end
endmodule // test_motion_irq_config_output
